// [rtl/panel_pkg.sv]
// Purpose: shared constants, register map and carrier types of the front-panel logic
// Assumes: 20 MHz module clock, AXI4-Lite register access with 32-bit data
// Notes: offsets are byte addresses of aligned words
package panel_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned NUM_BYTES    = 6;
  // indicator stretch time in milliseconds, and its cycle count
  localparam int unsigned STRETCH_MS   = 200;
  localparam int unsigned STRETCH_CYC  = (CLK_HZ / 1000) * STRETCH_MS;
  // self-test settle time per step in microseconds, and its cycle count
  localparam int unsigned SETTLE_US    = 1;
  localparam int unsigned SETTLE_CYC   = (CLK_HZ / 1_000_000) * SETTLE_US;
  // backplane address arithmetic
  localparam logic [15:0] ADDR_STEP    = 16'h0040;
  localparam logic [15:0] ADDR_BASE    = 16'hC000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_POL       = 8'h04;
  localparam logic [7:0] OFS_DIR       = 8'h08;
  localparam logic [7:0] OFS_FLOAT     = 8'h0C;
  localparam logic [7:0] OFS_OUTLO     = 8'h10;
  localparam logic [7:0] OFS_OUTHI     = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_INLO      = 8'h1C;
  localparam logic [7:0] OFS_INHI      = 8'h20;
  localparam logic [7:0] OFS_EVENT     = 8'h24;

  // control register bit positions
  localparam int unsigned CTRL_RESET   = 0;
  localparam int unsigned CTRL_TEST    = 1;
  localparam int unsigned CTRL_STROBE  = 2;
  localparam int unsigned CTRL_TAKE    = 3;
  localparam int unsigned CTRL_ERRSET  = 4;
  localparam int unsigned CTRL_ERRCLR  = 5;
  // polarity register bit positions (1 = rising edge / active high)
  localparam int unsigned POL_ACCEPT   = 0;
  localparam int unsigned POL_OUTVAL   = 1;
  localparam int unsigned POL_INVAL    = 2;
  localparam int unsigned POL_TAKEN    = 3;
  localparam int unsigned POL_FLOAT    = 8;

  // reset values
  localparam logic [13:0] POL_RESET    = 14'h3F0F;
  localparam logic [5:0]  DIR_RESET    = 6'h00;
  localparam logic [5:0]  FLOAT_RESET  = 6'h00;

  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic       busLed;
    logic       irqLed;
    logic       acceptLed;
    logic       outValidLed;
    logic       inValidLed;
    logic       takenLed;
    logic [2:0] byteLed;
    logic       errLed;
    logic       dirLed;
    logic       floatLed;
    logic [7:0] bitLed;
    logic       failLed;
  } panel_led_t;

  // binary byte number to indicator pattern, one lit lamp per one bit
  function automatic logic [2:0] byte_lamps(input logic [2:0] sel);
    return sel;
  endfunction

  // decoded backplane base address from the two address digits
  function automatic logic [15:0] base_addr(input logic [7:0] la);
    return 16'(ADDR_STEP * {8'h00, la}) + ADDR_BASE;
  endfunction

endpackage

// [rtl/pulse_stretch.sv]
// Purpose: retriggerable stretcher keeping a lamp lit for a fixed time
// Assumes: single clock, event input on the same clock
// Notes: a new trigger restarts the count, so steady triggers keep it lit
`timescale 1ns/10ps
module pulse_stretch #(
  parameter int unsigned CYCLES = 4_000_000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trig,
  output logic      lit
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        lit;
  } st_t;

  st_t stQ;
  st_t stD;

  initial begin
    if (CYCLES < 1)
    begin
      $error("pulse_stretch: CYCLES must be at least one");
    end
  end

  // reload on trigger, count down otherwise
  always_comb
  begin
    stD = stQ;
    if (trig)
    begin
      stD.cnt = 32'(CYCLES - 1);
      stD.lit = 1'b1;
    end
    else if (stQ.cnt != 32'h0000_0000)
    begin
      stD.cnt = stQ.cnt - 32'h0000_0001;
    end
    else
    begin
      stD.lit = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stQ <= '0;
    end
    else
    begin
      stQ <= stD;
    end
  end

  assign lit = stQ.lit;
endmodule // pulse_stretch

// [rtl/panel_logic.sv]
// Purpose: front-panel indicators, switches, handshake lines and loop-back self test
// Assumes: 20 MHz clk, registers over AXI4-Lite, byte-select, float-request and strobe pins pass a 3-stage synchroniser
// Notes: command parsing and transfer sequencing live elsewhere
// Operation
// - selector values 1 to 7 give the same interrupt level
// - selector 0, 8 or 9 disables all interrupts
// - protocol events raise an interrupt on the selected level
// - halt on: control reset bit restores power-up state and defaults
// - halt off: control reset bit is ignored
// - each byte-select press advances the displayed byte
// - fail output and lamp on self-test fail, rail loss or cpu fail
// - bus-cycle lamp stretched to about 0.2 s, steady access keeps it lit
// - interrupt-request lamp lights on request, stretched the same way
// - accept lamp sets on far-end strobe, clears on next output-valid strobe command
// - output-valid lamp lit while that line is low
// - input-valid lamp sets on strobe, clears when input data is read
// - input-taken lamp lit while that line is low
// - three lamps show the displayed byte number 0 to 5
// - programming-fault lamp stays lit until the error is cleared
// - direction lamp lit when the displayed byte is an output
// - float lamp lit when the displayed byte is tri-stated
// - eight bit lamps show displayed byte levels, msb leftmost
// - self test at power-up and on command, driven and tri-stated
// - far-end accept strobe edge sense is programmable
// - output-valid line edge sense is programmable
// - six float requests tri-state their byte, level programmable
// - base address is 64 times logical address plus 49152
// - far-end input-valid strobe edge sense is programmable
// - input-taken line edge sense is programmable
`timescale 1ns/10ps
module panel_logic
  import panel_pkg::*;
#(
  parameter int unsigned STRETCH = STRETCH_CYC,
  parameter int unsigned SETTLE  = SETTLE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire panel_pkg::axi_req_t axiReq,
  output panel_pkg::axi_rsp_t      axiRsp,
  input  wire logic [3:0]         irqSelect,
  input  wire logic               haltOn,
  input  wire logic               byteButton,
  input  wire logic [7:0]         logicalAddr,
  input  wire logic               busCycle,
  input  wire logic               protocolEvent,
  input  wire logic               railLost,
  input  wire logic               cpuFail,
  input  wire logic               farEndAcceptsStrobe,
  input  wire logic               inputValidStrobe,
  input  wire logic [5:0]         byteFloatRequest,
  input  wire logic [47:0]        loopbackIn,
  output logic [47:0]             ioOut,
  output logic [5:0]              ioOutEn,
  output logic                    outputValidStrobe,
  output logic                    inputTakenStrobe,
  output logic [2:0]              irqLevel,
  output logic                    irqReq,
  output logic                    sysFail,
  output logic [15:0]             baseAddr,
  output panel_pkg::panel_led_t   leds
);
  localparam int unsigned NPIN = 9;
  typedef enum logic [2:0] {ST_IDLE, ST_DRIVE, ST_CHK_DRV, ST_FLOAT, ST_CHK_FLT} test_t;

  typedef struct packed {
    logic [NPIN-1:0] syn1;
    logic [NPIN-1:0] syn2;
    logic [NPIN-1:0] syn3;
    logic            awHeld;
    logic [7:0]      awAddr;
    logic            wHeld;
    logic [31:0]     wData;
    logic            bValid;
    logic [1:0]      bResp;
    logic            rValid;
    logic [31:0]     rData;
    logic [1:0]      rResp;
    logic            awRdy;
    logic            wRdy;
    logic            arRdy;
    logic [13:0]     pol;
    logic [5:0]      dir;
    logic [5:0]      floatCmd;
    logic [47:0]     outData;
    logic [47:0]     inData;
    logic            acceptEv;
    logic            inValidEv;
    logic            outValLine;
    logic            takenLine;
    logic            progErr;
    logic            testFail;
    logic [2:0]      dispByte;
    test_t           test;
    logic [31:0]     wait_;
    logic [2:0]      irqLevel;
    logic            irqReq;
    logic            sysFail;
    logic [15:0]     baseAddr;
    logic [47:0]     ioOut;
    logic [5:0]      ioOutEn;
    logic            outValidStrobe;
    logic            inputTakenStrobe;
    panel_led_t      leds;
  } st_t;

  st_t  stQ;
  st_t  stD;
  logic busLit;
  logic irqLit;

  initial begin
    if (STRETCH < 1 || SETTLE < 1)
    begin
      $error("panel_logic: STRETCH and SETTLE must be at least one");
    end
  end

  // byte field of a 48-bit word
  function automatic logic [7:0] pick_byte(input logic [47:0] w, input logic [2:0] n);
    return w[8*n +: 8];
  endfunction

  // 32-bit write merged under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  pulse_stretch #(.CYCLES(STRETCH)) u_busStretch (
    .clk  (clk),
    .rst  (rst),
    .trig (busCycle),
    .lit  (busLit)
  );

  pulse_stretch #(.CYCLES(STRETCH)) u_irqStretch (
    .clk  (clk),
    .rst  (rst),
    .trig (stQ.irqReq),
    .lit  (irqLit)
  );

  always_comb
  begin
    logic [NPIN-1:0] pinNow;
    logic [NPIN-1:0] pinRise;
    logic [NPIN-1:0] pinFall;
    logic            accEdge;
    logic            ivEdge;
    logic            press;
    logic            swReset;
    logic            newOut;
    logic            readIn;
    logic            startTest;
    logic [5:0]      extFloat;
    logic [5:0]      floatAll;
    logic [31:0]     wv;
    stD       = stQ;
    pinNow    = '0;
    pinRise   = '0;
    pinFall   = '0;
    accEdge   = 1'b0;
    ivEdge    = 1'b0;
    press     = 1'b0;
    extFloat  = '0;
    floatAll  = '0;
    swReset   = 1'b0;
    newOut    = 1'b0;
    readIn    = 1'b0;
    startTest = 1'b0;
    wv        = '0;

    // three-stage pin synchroniser, change counted when stages 2 and 3 differ
    stD.syn1 = {byteButton, byteFloatRequest, inputValidStrobe, farEndAcceptsStrobe};
    stD.syn2 = stQ.syn1;
    stD.syn3 = stQ.syn2;
    for (int i = 0; i < NPIN; i++)
    begin
      pinNow[i]  = stQ.syn2[i];
      pinRise[i] = stQ.syn2[i] & ~stQ.syn3[i];
      pinFall[i] = ~stQ.syn2[i] & stQ.syn3[i];
    end
    accEdge = stQ.pol[POL_ACCEPT] ? pinRise[0] : pinFall[0];
    ivEdge  = stQ.pol[POL_INVAL] ? pinRise[1] : pinFall[1];
    press   = pinRise[8];

    // register slave: address and data in either order, one write at a time
    stD.outValidStrobe   = stQ.outValidStrobe;
    if (axiReq.awvalid && stQ.awRdy)
    begin
      stD.awHeld = 1'b1;
      stD.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && stQ.wRdy)
    begin
      stD.wHeld = 1'b1;
      stD.wData = axiReq.wdata;
    end
    if (stQ.awHeld && stQ.wHeld)
    begin
      stD.awHeld = 1'b0;
      stD.wHeld  = 1'b0;
      stD.bValid = 1'b1;
      stD.bResp  = RESP_OKAY;
      wv         = stQ.wData;
      unique case ({stQ.awAddr[7:2], 2'b00})
        OFS_CTRL:
        begin
          swReset   = wv[CTRL_RESET] & haltOn;
          startTest = wv[CTRL_TEST];
          newOut    = wv[CTRL_STROBE];
          readIn    = wv[CTRL_TAKE];
          if (wv[CTRL_ERRSET])
          begin
            stD.progErr = 1'b1;
          end
          else if (wv[CTRL_ERRCLR])
          begin
            stD.progErr = 1'b0;
          end
        end
        OFS_POL:   stD.pol      = 14'(merge(32'(stQ.pol), wv, 4'hF));
        OFS_DIR:   stD.dir      = wv[5:0];
        OFS_FLOAT: stD.floatCmd = wv[5:0];
        OFS_OUTLO: stD.outData[31:0]  = wv;
        OFS_OUTHI: stD.outData[47:32] = wv[15:0];
        default:   stD.bResp    = RESP_SLVERR;
      endcase
    end
    if (stQ.bValid && axiReq.bready)
    begin
      stD.bValid = 1'b0;
    end

    if (axiReq.arvalid && stQ.arRdy)
    begin
      stD.rValid = 1'b1;
      stD.rResp  = RESP_OKAY;
      unique case ({axiReq.araddr[7:2], 2'b00})
        OFS_CTRL:   stD.rData = {26'h000_0000, stQ.progErr, 5'h00};
        OFS_POL:    stD.rData = {18'h0_0000, stQ.pol};
        OFS_DIR:    stD.rData = {26'h000_0000, stQ.dir};
        OFS_FLOAT:  stD.rData = {26'h000_0000, stQ.floatCmd};
        OFS_OUTLO:  stD.rData = stQ.outData[31:0];
        OFS_OUTHI:  stD.rData = {16'h0000, stQ.outData[47:32]};
        OFS_STATUS: stD.rData = {18'h0_0000, stQ.testFail, stQ.dispByte, stQ.test != ST_IDLE,
                                 stQ.sysFail, stQ.irqLevel, stQ.outValLine, stQ.takenLine,
                                 stQ.acceptEv, stQ.inValidEv, stQ.progErr};
        OFS_INLO:
        begin
          stD.rData = stQ.inData[31:0];
          stD.inValidEv = 1'b0;                 // read clears
        end
        OFS_INHI:   stD.rData = {16'h0000, stQ.inData[47:32]};
        OFS_EVENT:  stD.rData = {26'h000_0000, pinNow[7:2]};
        default:
        begin
          stD.rData = '0;
          stD.rResp = RESP_SLVERR;
        end
      endcase
    end
    if (stQ.rValid && axiReq.rready)
    begin
      stD.rValid = 1'b0;
    end
    // ready flags registered from the next held and busy state
    stD.awRdy = !stD.awHeld && !stD.bValid;
    stD.wRdy  = !stD.wHeld && !stD.bValid;
    stD.arRdy = !stD.rValid;
    if (readIn)
    begin
      stD.inValidEv = 1'b0;
    end

    // handshake events; a set in the same cycle beats a clear
    stD.outValLine = newOut;                    // one-cycle pulse, edge set by polarity
    stD.takenLine  = readIn;                    // one-cycle pulse, edge set by polarity
    if (newOut)
    begin
      stD.acceptEv   = 1'b0;
    end
    if (accEdge)
    begin
      stD.acceptEv = 1'b1;
    end
    if (ivEdge)
    begin
      stD.inValidEv = 1'b1;
      stD.inData    = loopbackIn;
    end

    // byte select, wrapping after the last byte
    if (press)
    begin
      stD.dispByte = (stQ.dispByte == 3'(NUM_BYTES - 1)) ? 3'h0 : stQ.dispByte + 3'h1;
    end

    // float: commanded or external request at programmed level
    extFloat = ~(pinNow[7:2] ^ stQ.pol[POL_FLOAT +: 6]);
    floatAll = stQ.floatCmd | extFloat;

    // loop-back self test: drive and compare, then float and compare
    stD.wait_ = (stQ.wait_ != 32'h0000_0000) ? stQ.wait_ - 32'h0000_0001 : stQ.wait_;
    unique case (stQ.test)
      ST_IDLE:
      begin
        if (startTest)
        begin
          stD.test     = ST_DRIVE;
          stD.testFail = 1'b0;
        end
      end
      ST_DRIVE:
      begin
        stD.wait_ = 32'(SETTLE);
        stD.test  = ST_CHK_DRV;
      end
      ST_CHK_DRV:
      begin
        if (stQ.wait_ == 32'h0000_0000)
        begin
          if (loopbackIn != stQ.outData)
          begin
            stD.testFail = 1'b1;
          end
          stD.wait_ = 32'(SETTLE);
          stD.test  = ST_FLOAT;
        end
      end
      ST_FLOAT:
      begin
        if (stQ.wait_ == 32'h0000_0000)
        begin
          stD.test = ST_CHK_FLT;
        end
      end
      ST_CHK_FLT:
      begin
        if (loopbackIn != stQ.outData)
        begin
          stD.testFail = 1'b1;                  // internal path still loops in tri-state
        end
        stD.test = ST_IDLE;
      end
    endcase

    // registered outputs
    stD.ioOut = stQ.outData;
    for (int b = 0; b < NUM_BYTES; b++)
    begin
      stD.ioOutEn[b] = (stQ.test == ST_FLOAT || stQ.test == ST_CHK_FLT) ? 1'b0 :
                       (stQ.test != ST_IDLE) ? 1'b1 : (stQ.dir[b] & ~floatAll[b]);
    end
    stD.irqLevel = (irqSelect >= 4'h1 && irqSelect <= 4'h7) ? irqSelect[2:0] : 3'h0;
    stD.irqReq   = protocolEvent && stD.irqLevel != 3'h0;
    stD.sysFail  = stQ.testFail | railLost | cpuFail;
    stD.baseAddr = base_addr(logicalAddr);
    stD.outValidStrobe   = stQ.outValLine ^ ~stQ.pol[POL_OUTVAL];
    stD.inputTakenStrobe = stQ.takenLine ^ ~stQ.pol[POL_TAKEN];
    stD.leds.busLed      = busLit;
    stD.leds.irqLed      = irqLit;
    stD.leds.acceptLed   = stQ.acceptEv;
    stD.leds.outValidLed = ~stD.outValidStrobe;
    stD.leds.inValidLed  = stQ.inValidEv;
    stD.leds.takenLed    = ~stD.inputTakenStrobe;
    stD.leds.byteLed     = byte_lamps(stQ.dispByte);
    stD.leds.errLed      = stQ.progErr;
    stD.leds.dirLed      = stQ.dir[stQ.dispByte];
    stD.leds.floatLed    = floatAll[stQ.dispByte];
    stD.leds.bitLed      = stQ.dir[stQ.dispByte] ? pick_byte(stQ.outData, stQ.dispByte)
                                                 : pick_byte(loopbackIn, stQ.dispByte);
    stD.leds.failLed     = stD.sysFail;

    // halt-enabled reset: defaults back, self test rerun as at power-up
    if (swReset)
    begin
      stD.pol        = POL_RESET;
      stD.dir        = DIR_RESET;
      stD.floatCmd   = FLOAT_RESET;
      stD.outData    = '0;
      stD.progErr    = 1'b0;
      stD.acceptEv   = 1'b0;
      stD.inValidEv  = 1'b0;
      stD.outValLine = 1'b0;
      stD.takenLine  = 1'b0;
      stD.dispByte   = 3'h0;
      stD.testFail   = 1'b0;
      stD.test       = ST_DRIVE;
    end
  end

  // state register; power-up starts the self test
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stQ      <= '0;
      stQ.pol  <= POL_RESET;
      stQ.test <= ST_DRIVE;
    end
    else
    begin
      stQ <= stD;
    end
  end

  assign axiRsp.awready     = stQ.awRdy;
  assign axiRsp.wready      = stQ.wRdy;
  assign axiRsp.bvalid      = stQ.bValid;
  assign axiRsp.bresp       = stQ.bResp;
  assign axiRsp.arready     = stQ.arRdy;
  assign axiRsp.rvalid      = stQ.rValid;
  assign axiRsp.rdata       = stQ.rData;
  assign axiRsp.rresp       = stQ.rResp;
  assign ioOut              = stQ.ioOut;
  assign ioOutEn            = stQ.ioOutEn;
  assign outputValidStrobe  = stQ.outValidStrobe;
  assign inputTakenStrobe   = stQ.inputTakenStrobe;
  assign irqLevel           = stQ.irqLevel;
  assign irqReq             = stQ.irqReq;
  assign sysFail            = stQ.sysFail;
  assign baseAddr           = stQ.baseAddr;
  assign leds               = stQ.leds;
endmodule // panel_logic

// [test/panel_logic_properties.sv]
// Purpose: port-level checks of the panel logic
// Assumes: one clock, rst async active high
// Notes: lamp latencies allow for the pin synchronisers
`timescale 1ns/10ps
module panel_logic_chk
  import panel_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic [3:0]            irqSelect,
  input wire logic                  busCycle,
  input wire logic                  railLost,
  input wire logic                  cpuFail,
  input wire logic                  outputValidStrobe,
  input wire logic                  inputTakenStrobe,
  input wire logic [2:0]            irqLevel,
  input wire logic                  irqReq,
  input wire logic                  sysFail,
  input wire panel_pkg::panel_led_t leds
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // selector left alone long enough to settle
  sequence selHeld;
    $stable(irqSelect) [*6];
  endsequence
  // lamp lit, then held by the stretcher
  sequence busLit;
    ##[1:3] leds.busLed ##1 leds.busLed [*7];
  endsequence
  chk_irq_level_map: assert property
    (selHeld |-> irqLevel == ((irqSelect inside {[1:7]}) ? irqSelect[2:0] : 3'h0))
    else $error("irq level does not follow selector");
  chk_irq_gated: assert property (irqReq |-> irqLevel != 3'h0)
    else $error("request with interrupts disabled");
  chk_bus_stretch: assert property (busCycle |-> busLit)
    else $error("bus lamp not stretched");
  chk_irq_lamp: assert property (irqReq |-> ##[1:3] leds.irqLed)
    else $error("request lamp dark");
  chk_outval_lamp: assert property
    ($stable(outputValidStrobe) [*3] |-> leds.outValidLed == !outputValidStrobe)
    else $error("output-valid lamp wrong");
  chk_taken_lamp: assert property
    ($stable(inputTakenStrobe) [*3] |-> leds.takenLed == !inputTakenStrobe)
    else $error("input-taken lamp wrong");
  chk_byte_range: assert property (leds.byteLed <= 3'd5)
    else $error("byte lamps out of range");
  chk_byte_step: assert property
    ($changed(leds.byteLed) |-> leds.byteLed == 3'd0 || leds.byteLed == $past(leds.byteLed) + 3'd1)
    else $error("byte lamps skipped");
  chk_fail_raise: assert property ((railLost || cpuFail) |-> ##[1:5] sysFail && leds.failLed)
    else $error("fail not raised");
endmodule // panel_logic_chk
bind panel_logic panel_logic_chk u_chk (.clk, .rst, .irqSelect, .busCycle, .railLost, .cpuFail, .outputValidStrobe,
  .inputTakenStrobe, .irqLevel, .irqReq, .sysFail, .leds);

// [test/far_end_model.sv]
// Purpose: far-end handshaking device and loop-back wiring
// Assumes: strobe lines idle low, true event on the rising edge
// Notes: bytes not driven by the block carry far-end data
`timescale 1ns/10ps
module far_end_model (
  input  wire logic        clk,
  input  wire logic [47:0] ioOut,
  input  wire logic [5:0]  ioOutEn,
  output logic             acceptStrobe,
  output logic             validStrobe,
  output logic [5:0]       floatReq,
  output logic [47:0]      loopback
);
  logic [47:0] extData = 48'h0;
  initial
  begin
    acceptStrobe = 0;
    validStrobe = 0;
    floatReq = 0;
  end
  // driven bytes loop back, others show far-end data
  always_comb
    for (int b = 0; b < 6; b++)
      loopback[b*8+:8] = ioOutEn[b] ? ioOut[b*8+:8] : extData[b*8+:8];
  // one strobe, data set up ahead of the edge
  task automatic strobe(input bit valid, input logic [47:0] v);
    extData <= v;
    @(posedge clk);
    if (valid)
      validStrobe <= 1;
    else
      acceptStrobe <= 1;
    repeat (4) @(posedge clk);
    validStrobe <= 0;
    acceptStrobe <= 0;
    repeat (6) @(posedge clk);
  endtask
  // per-byte float requests
  task automatic set_float(input logic [5:0] f);
    floatReq <= f;
    repeat (6) @(posedge clk);
  endtask
endmodule // far_end_model

// [test/panel_logic_bench.sv]
// Purpose: self-checking bench for the panel logic
// Assumes: 20 MHz clock, short stretch and settle counts
// Notes: bus ready flags are sampled at the falling edge
`timescale 1ns/10ps
module panel_logic_bench;
  import panel_pkg::*;
  localparam int unsigned STR = 20;
  logic        clk, rst, haltOn, btn, busCycle, protocolEvent, railLost, cpuFail;
  logic        ovs, its, accS, valS, sysFail, irqReq;
  logic [3:0]  irqSelect;
  logic [2:0]  irqLevel;
  logic [5:0]  ioOutEn, fReq;
  logic [15:0] baseAddr;
  logic [31:0] d;
  logic [1:0]  p;
  logic [47:0] ioOut, loopbackIn;
  axi_req_t    q;
  axi_rsp_t    r;
  panel_led_t  leds;
  int          error_cnt = 0;
  int          n_compared = 0;
  panel_logic #(.STRETCH(STR), .SETTLE(4)) u_dut (.clk, .rst, .axiReq(q), .axiRsp(r), .irqSelect, .haltOn,
    .byteButton(btn), .logicalAddr(8'h15), .busCycle, .protocolEvent, .railLost, .cpuFail,
    .farEndAcceptsStrobe(accS), .inputValidStrobe(valS), .byteFloatRequest(fReq), .loopbackIn, .ioOut,
    .ioOutEn, .outputValidStrobe(ovs), .inputTakenStrobe(its), .irqLevel, .irqReq, .sysFail, .baseAddr, .leds);
  far_end_model u_far (.clk, .ioOut, .ioOutEn, .acceptStrobe(accS), .validStrobe(valS), .floatReq(fReq),
    .loopback(loopbackIn));
  // free-running clock
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] g, input logic [47:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bus write or read, each channel released when taken
  task automatic axi(input bit isWr, input logic [7:0] a, input logic [31:0] v);
    int n;
    logic aw, w, ar, b;
    n = 0;
    b = 0;
    @(posedge clk);
    q.awaddr <= a;
    q.araddr <= a;
    q.wdata <= v;
    q.awvalid <= isWr;
    q.wvalid <= isWr;
    q.bready <= isWr;
    q.arvalid <= !isWr;
    q.rready <= !isWr;
    while (!b && n < 40)
    begin
      @(negedge clk);
      aw = r.awready;
      w = r.wready;
      ar = r.arready;
      b = isWr ? r.bvalid : r.rvalid;
      d = r.rdata;
      p = isWr ? r.bresp : r.rresp;
      n++;
      @(posedge clk);
      if (aw) q.awvalid <= 0;
      if (w) q.wvalid <= 0;
      if (ar) q.arvalid <= 0;
      if (b) q.bready <= 0;
      if (b) q.rready <= 0;
    end
    if (!b)
    begin
      error_cnt++;
      $display("mismatch at %0t: bus timeout", $time);
      complete_run;
    end
  endtask
  task automatic t_btn;
    for (int i = 1; i <= 7; i++)
    begin
      btn <= 1;
      tick(4);
      btn <= 0;
      tick(6);
      cmp(leds.byteLed, 48'(i % 6));
    end
    $display("button test done");
  endtask
  task automatic t_irq;
    logic [3:0] sel[10] = '{0, 8, 9, 1, 2, 3, 4, 5, 6, 7};
    int n;
    for (int i = 0; i < 10; i++)
    begin
      irqSelect <= sel[i];
      tick(8);
      cmp(irqLevel, (sel[i] inside {[1:7]}) ? sel[i][2:0] : 3'h0);
      protocolEvent <= 1;
      tick(1);
      protocolEvent <= 0;
      n = 0;
      while (irqReq !== 1'b1 && n < 10)
      begin
        tick(1);
        n++;
      end
      cmp(irqReq, sel[i] inside {[1:7]});
    end
    $display("irq test done");
  endtask
  task automatic t_bus;
    busCycle <= 1;
    tick(3 * STR);
    cmp(leds.busLed, 1);
    busCycle <= 0;
    tick(STR + 10);
    cmp(leds.busLed, 0);
    $display("bus lamp test done");
  endtask
  task automatic t_hs;
    axi(1, OFS_DIR, 32'h0000_0002);
    axi(1, OFS_OUTLO, 32'h0000_5A00);
    tick(6);
    cmp(leds.dirLed, 1);
    cmp(leds.bitLed, 8'h5A);
    cmp(ioOut, 48'h0000_0000_5A00);
    u_far.strobe(0, 48'h0);
    cmp(leds.acceptLed, 1);
    axi(1, OFS_CTRL, 32'h0000_0004);
    tick(6);
    cmp({ovs, leds.outValidLed, leds.acceptLed}, 3'b010);
    u_far.strobe(1, 48'h1122_3344_5A77);
    cmp(leds.inValidLed, 1);
    axi(0, OFS_INLO, 32'h0);
    cmp(d, 32'h3344_5A77);
    tick(6);
    cmp(leds.inValidLed, 0);
    axi(1, OFS_CTRL, 32'h0000_0008);
    tick(6);
    cmp({its, leds.takenLed}, 2'b01);
    u_far.set_float(6'h02);
    cmp({leds.floatLed, ioOutEn[1]}, 2'b10);
    axi(1, OFS_POL, 32'h0000_3D0F);
    tick(6);
    cmp(ioOutEn[1], 1);
    u_far.set_float(6'h00);
    u_far.strobe(0, 48'h0);
    $display("handshake test done");
  endtask
  task automatic t_err;
    axi(1, OFS_CTRL, 32'h0000_0010);
    tick(20);
    cmp(leds.errLed, 1);
    axi(1, OFS_CTRL, 32'h0000_0020);
    tick(3);
    cmp(leds.errLed, 0);
    axi(0, 8'h3C, 32'h0);
    cmp({p, d}, {RESP_SLVERR, 32'h0});
    $display("error test done");
  endtask
  task automatic t_halt;
    haltOn <= 0;
    axi(1, OFS_CTRL, 32'h0000_0001);
    tick(30);
    axi(0, OFS_DIR, 32'h0);
    cmp(d, 32'h2);
    haltOn <= 1;
    axi(1, OFS_CTRL, 32'h0000_0001);
    tick(30);
    axi(0, OFS_DIR, 32'h0);
    cmp(d, 32'(DIR_RESET));
    axi(0, OFS_POL, 32'h0);
    cmp(d, 32'(POL_RESET));
    axi(1, OFS_CTRL, 32'h0000_0002);
    tick(30);
    cmp(sysFail, 0);
    railLost <= 1;
    tick(8);
    cmp({sysFail, leds.failLed}, 2'b11);
    railLost <= 0;
    cpuFail <= 1;
    tick(8);
    cmp({sysFail, leds.failLed}, 2'b11);
    $display("halt test done");
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    rst = 1;
    q = '0;
    haltOn = 1;
    btn = 0;
    busCycle = 0;
    protocolEvent = 0;
    railLost = 0;
    cpuFail = 0;
    irqSelect = 0;
    tick(10);
    rst <= 0;
    tick(30);
    cmp({baseAddr, sysFail}, {16'hC540, 1'b0});
    t_btn;
    t_irq;
    t_bus;
    t_hs;
    t_err;
    t_halt;
    complete_run;
  end
endmodule // panel_logic_bench
